// ===== src/wdctl_regs.vh
// register offsets, field positions, codes and timing counts for the watchdog
`ifndef WDCTL_REGS_VH
`define WDCTL_REGS_VH

// register byte offsets
`define WDCTL_OFF_MODE      8'h00
`define WDCTL_OFF_CMD       8'h01
`define WDCTL_OFF_STATUS    8'h02
`define WDCTL_OFF_MASK      8'h03
`define WDCTL_OFF_STATE     8'h04

// mode register fields
`define WDCTL_MODE_EN_BIT   7
`define WDCTL_MODE_TSEL_HI  6
`define WDCTL_MODE_TSEL_LO  5
`define WDCTL_MODE_I2_BIT   2
`define WDCTL_MODE_RST_BIT  1
`define WDCTL_MODE_RESET    8'h80

// command codes
`define WDCTL_CODE_CLEAR    8'h4E
`define WDCTL_CODE_DISABLE  8'hB1

// status bits
`define WDCTL_ST_OVF_BIT    0
`define WDCTL_ST_RST_BIT    1

// counter length in stages and internal reset pulse length in system clocks
`define WDCTL_CNT_W         22
`define WDCTL_RST_STATES    5'h19
`define WDCTL_RST_W         5

`endif

// ===== src/wdctl_sync.v
// two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
module wdctl_sync (
    input  wire i_sys_clk,
    input  wire i_rst,
    input  wire i_ce,
    input  wire i_async,
    output wire o_sync
);
    reg meta_q;
    reg sync_q;

    // first flop feeds only the second
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else if (i_ce) begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

// ===== src/wdctl_top.v
// runaway timer: mode and command registers, counter, nmi and internal reset
//
// Function
// - two-bit detection select, resets to 00
// - enable bit resets to one
// - disable needs enable low plus code
// - writing enable one re-enables immediately
// - reset connect bit, resets to zero
// - clear code zeroes the counter
// - 22-stage counter, four power-of-two taps
// - overflow raises the watchdog nmi
// - idle2 bit decides run or halt
// - internal reset pulse of 25 states
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "wdctl_regs.vh"
module wdctl_top (
    input  wire       i_sys_clk,
    input  wire       i_rst,
    input  wire       i_ce,
    input  wire       i_idle2,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    output reg  [7:0] o_rdata,
    output wire       o_wd_nmi_request,
    output wire       o_wd_reset,
    output wire       o_irq
);
    reg  [1:0]                detection_time_sel_q;
    reg                       wd_enable_bit_q;
    reg                       reset_connect_bit_q;
    reg                       idle2_run_bit_q;
    reg                       disabled_q;
    reg  [`WDCTL_CNT_W-1:0]   cnt_q;
    reg                       tap_q;
    reg                       nmi_q;
    reg  [`WDCTL_RST_W-1:0]   rst_cnt_q;
    reg  [1:0]                status_q;
    reg  [1:0]                mask_q;
    reg  [7:0]                rdata_d;
    reg                       tap_d;
    wire                      idle2_s;
    wire                      wr_mode;
    wire                      wr_cmd;
    wire                      wr_stat;
    wire                      cmd_clear;
    wire                      cmd_dis;
    wire                      run;
    wire                      tap_rise;
    wire                      fire_rst;

    // idle2 indication comes from the power controller, maybe another domain
    wdctl_sync u_idle2_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_async   (i_idle2),
        .o_sync    (idle2_s)
    );

    // write decode
    assign wr_mode   = i_wr && (i_addr == `WDCTL_OFF_MODE);
    assign wr_cmd    = i_wr && (i_addr == `WDCTL_OFF_CMD);
    assign wr_stat   = i_wr && (i_addr == `WDCTL_OFF_STATUS);
    assign cmd_clear = wr_cmd && (i_wdata == `WDCTL_CODE_CLEAR);
    assign cmd_dis   = wr_cmd && (i_wdata == `WDCTL_CODE_DISABLE);

    // counting halts when disabled, or in idle2 unless told to run
    assign run = !disabled_q && !(idle2_s && !idle2_run_bit_q);

    // mode register; reset values give a live watchdog straight away
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            detection_time_sel_q <= 2'h0;
            wd_enable_bit_q      <= 1'b1;
            reset_connect_bit_q  <= 1'b0;
            idle2_run_bit_q      <= 1'b0;
        end else if (i_ce && wr_mode) begin
            detection_time_sel_q <= i_wdata[`WDCTL_MODE_TSEL_HI:`WDCTL_MODE_TSEL_LO];
            wd_enable_bit_q      <= i_wdata[`WDCTL_MODE_EN_BIT];
            reset_connect_bit_q  <= i_wdata[`WDCTL_MODE_RST_BIT];
            idle2_run_bit_q      <= i_wdata[`WDCTL_MODE_I2_BIT];
        end
    end

    // disable state: two-key entry, one-step exit
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            disabled_q <= 1'b0;
        end else if (i_ce) begin
            if (wr_mode && i_wdata[`WDCTL_MODE_EN_BIT]) begin
                disabled_q <= 1'b0;
            end else if (cmd_dis && !wd_enable_bit_q) begin
                disabled_q <= 1'b1;
            end
        end
    end

    // tap selection, 00..11 -> bits 14,16,18,20: edge on bit n-1 falling
    // is one full 2^n period, bit 21 makes the counter 22 stages
    always @* begin
        case (detection_time_sel_q)
            2'h0:    tap_d = cnt_q[14];
            2'h1:    tap_d = cnt_q[16];
            2'h2:    tap_d = cnt_q[18];
            2'h3:    tap_d = cnt_q[20];
            default: tap_d = cnt_q[14];
        endcase
    end

    // overflow is the selected bit falling back to zero
    assign tap_rise = tap_q && !tap_d && run && !cmd_clear;

    // binary counter on the system clock
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= {`WDCTL_CNT_W{1'b0}};
            tap_q <= 1'b0;
        end else if (i_ce) begin
            if (cmd_clear) begin
                cnt_q <= {`WDCTL_CNT_W{1'b0}};
                tap_q <= 1'b0;
            end else if (run) begin
                cnt_q <= cnt_q + {{(`WDCTL_CNT_W-1){1'b0}}, 1'b1};
                tap_q <= tap_d;
            end else begin
                tap_q <= tap_d;
            end
        end
    end

    // nmi request is a one-cycle pulse per overflow
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            nmi_q <= 1'b0;
        end else if (i_ce) begin
            nmi_q <= tap_rise;
        end
    end
    assign o_wd_nmi_request = nmi_q;

    // internal reset pulse; does not touch the external pin
    assign fire_rst = tap_rise && reset_connect_bit_q;
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rst_cnt_q <= {`WDCTL_RST_W{1'b0}};
        end else if (i_ce) begin
            if (fire_rst) begin
                rst_cnt_q <= `WDCTL_RST_STATES;
            end else if (rst_cnt_q != {`WDCTL_RST_W{1'b0}}) begin
                rst_cnt_q <= rst_cnt_q - {{(`WDCTL_RST_W-1){1'b0}}, 1'b1};
            end
        end
    end
    assign o_wd_reset = (rst_cnt_q != {`WDCTL_RST_W{1'b0}});

    // sticky status, write one clears; a new event wins over the clear
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            status_q <= 2'h0;
            mask_q   <= 2'h0;
        end else if (i_ce) begin
            status_q[`WDCTL_ST_OVF_BIT] <= tap_rise ||
                (status_q[`WDCTL_ST_OVF_BIT] && !(wr_stat && i_wdata[`WDCTL_ST_OVF_BIT]));
            status_q[`WDCTL_ST_RST_BIT] <= fire_rst ||
                (status_q[`WDCTL_ST_RST_BIT] && !(wr_stat && i_wdata[`WDCTL_ST_RST_BIT]));
            if (i_wr && (i_addr == `WDCTL_OFF_MASK)) begin
                mask_q <= i_wdata[1:0];
            end
        end
    end
    assign o_irq = |(status_q & mask_q);

    // read mux; command register is write-only and reads zero
    always @* begin
        rdata_d = 8'h00;
        case (i_addr)
            `WDCTL_OFF_MODE: begin
                rdata_d[`WDCTL_MODE_EN_BIT] = wd_enable_bit_q;
                rdata_d[`WDCTL_MODE_TSEL_HI:`WDCTL_MODE_TSEL_LO] = detection_time_sel_q;
                rdata_d[`WDCTL_MODE_I2_BIT] = idle2_run_bit_q;
                rdata_d[`WDCTL_MODE_RST_BIT] = reset_connect_bit_q;
            end
            `WDCTL_OFF_STATUS: rdata_d = {6'h00, status_q};
            `WDCTL_OFF_MASK:   rdata_d = {6'h00, mask_q};
            `WDCTL_OFF_STATE:  rdata_d = {7'h00, disabled_q};
            default:           rdata_d = 8'h00;
        endcase
    end

    // read data valid only the cycle after the strobe
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            o_rdata <= i_rd ? rdata_d : 8'h00;
        end
    end
endmodule

// ===== tb/wdctl_top_asserts.sv
// port checker for the watchdog control top
`timescale 1ns/1ns
`include "wdctl_regs.vh"
module wdctl_asserts (
    input wire       i_sys_clk,
    input wire       i_rst,
    input wire       i_ce,
    input wire       i_idle2,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire       i_wr,
    input wire       i_rd,
    input wire [7:0] o_rdata,
    input wire       o_wd_nmi_request,
    input wire       o_wd_reset,
    input wire       o_irq
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic [15:0] since_q;
    logic [4:0]  hi_q;
    // a clear write taken by the block
    sequence s_clr;
        i_ce && i_wr && i_addr == `WDCTL_OFF_CMD && i_wdata == `WDCTL_CODE_CLEAR;
    endsequence
    // cycles since clear, saturating so a lost clear still reads as long
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            since_q <= 16'h0000;
            hi_q    <= 5'h00;
        end else begin
            since_q <= (i_ce && i_wr && i_addr == `WDCTL_OFF_CMD && i_wdata == `WDCTL_CODE_CLEAR)
                       ? 16'h0000 : (since_q == 16'hFFFF ? since_q : since_q + 16'h0001);
            hi_q    <= o_wd_reset ? hi_q + 5'h01 : 5'h00;
        end
    end
    a_nmi_one_cycle: assert property (o_wd_nmi_request |=> !o_wd_nmi_request)
        else $error("nmi pulse longer than one cycle");
    a_clear_quiet: assert property (s_clr |=> !o_wd_nmi_request [*8])
        else $error("nmi right after clear");
    a_nmi_spacing: assert property (o_wd_nmi_request |-> since_q >= 16'h7FF0)
        else $error("nmi earlier than the shortest interval");
    a_rst_with_nmi: assert property ($rose(o_wd_reset) |-> o_wd_nmi_request)
        else $error("internal reset not started by overflow");
    a_rst_length: assert property ($fell(o_wd_reset) |-> hi_q == 5'd25)
        else $error("internal reset length wrong");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    a_cmd_wo: assert property (i_rd && i_addr == `WDCTL_OFF_CMD |=> o_rdata == 8'h00)
        else $error("command register readable");
    a_unmapped_zero: assert property (i_rd && i_addr > 8'h04 |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind wdctl_top wdctl_asserts u_chk (.i_sys_clk, .i_rst, .i_ce, .i_idle2, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .o_wd_nmi_request, .o_wd_reset, .o_irq);

// ===== tb/wdctl_top_test.sv
// self-checking bench for the watchdog control top
`timescale 1ns/1ns
`include "wdctl_regs.vh"
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin error_cnt++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module wdctl_top_test;
    reg       i_sys_clk, i_rst, i_wr, i_rd, i_idle2;
    reg [7:0] i_addr, i_wdata;
    wire [7:0] o_rdata;
    wire      o_wd_nmi_request, o_wd_reset, o_irq;
    int       error_cnt, check_count, cyc, n;
    wdctl_top dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(1'b1), .i_idle2(i_idle2),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_wd_nmi_request(o_wd_nmi_request), .o_wd_reset(o_wd_reset), .o_irq(o_irq));
    // 20 MHz system clock
    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    // hang guard, two overflow waits plus the late-clear wait fit inside
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 95000) begin
            error_cnt++;
            complete_run;
        end
    end
    task complete_run;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task rd(input [7:0] a, input [7:0] e, input string nm);
        @(posedge i_sys_clk);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 `CHK(nm, e, o_rdata)
    endtask
    // counts cycles to the nmi, bounded so a dead counter cannot hang
    task wait_nmi;
        n = 0;
        @(posedge i_sys_clk) #1;
        while (o_wd_nmi_request !== 1'b1 && n < 40000) begin
            @(posedge i_sys_clk) #1;
            n++;
        end
        `CHK("nmi delay", 1'b1, (n >= 32760 && n <= 32775))
    endtask
    initial begin
        i_rst = 1'b1; i_wr = 1'b0; i_rd = 1'b0; i_addr = 8'h00; i_wdata = 8'h00;
        i_idle2 = 1'b0;
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        rd(`WDCTL_OFF_MODE, `WDCTL_MODE_RESET, "mode");
        rd(`WDCTL_OFF_CMD, 8'h00, "command");
        rd(8'h20, 8'h00, "unmapped");
        rd(`WDCTL_OFF_STATE, 8'h00, "state");
        wr(`WDCTL_OFF_MASK, 8'h01);
        wr(`WDCTL_OFF_CMD, `WDCTL_CODE_CLEAR);
        wait_nmi;
        `CHK("reset unconnected", 1'b0, o_wd_reset)
        `CHK("irq set", 1'b1, o_irq)
        rd(`WDCTL_OFF_STATUS, 8'h01, "status");
        wr(`WDCTL_OFF_STATUS, 8'h01);
        rd(`WDCTL_OFF_STATUS, 8'h00, "status clear");
        `CHK("irq clear", 1'b0, o_irq)
        // late clear restarts the interval; idle2 without run bit halts it
        wr(`WDCTL_OFF_MODE, 8'h82);
        repeat (20000) @(posedge i_sys_clk);
        wr(`WDCTL_OFF_CMD, `WDCTL_CODE_CLEAR);
        i_idle2 <= 1'b1;
        repeat (1000) @(posedge i_sys_clk);
        i_idle2 <= 1'b0;
        wait_nmi;
        `CHK("internal reset", 1'b1, o_wd_reset)
        wr(`WDCTL_OFF_MODE, 8'h00);
        rd(`WDCTL_OFF_STATE, 8'h00, "still on");
        wr(`WDCTL_OFF_CMD, `WDCTL_CODE_CLEAR);
        wr(`WDCTL_OFF_CMD, `WDCTL_CODE_DISABLE);
        rd(`WDCTL_OFF_STATE, 8'h01, "disabled");
        wr(`WDCTL_OFF_MODE, 8'h20);
        rd(`WDCTL_OFF_MODE, 8'h20, "mode while off");
        rd(`WDCTL_OFF_STATE, 8'h01, "still off");
        wr(`WDCTL_OFF_MODE, 8'hA0);
        rd(`WDCTL_OFF_STATE, 8'h00, "re-enabled");
        complete_run;
    end
endmodule
